// File: rtl/latch_low_bit.sv
// Latched-low flag: any low sample sticks until the owner reads it
`timescale 1ns/100ps
`default_nettype none
module latch_low_bit (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Live level and read strobe
	input  wire logic level_in,
	input  wire logic read_in,
	// Latched value
	output var  logic bit_out
);
	import xaui_mdio_pkg::*;

	// A low level in the read cycle still lands, so no down event is lost
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_out <= LINK_INIT;
		end else if (read_in) begin
			bit_out <= level_in;
		end else begin
			bit_out <= bit_out & level_in;
		end
	end
endmodule : latch_low_bit
`default_nettype wire

// File: rtl/self_clear_bit.sv
// Self-clearing control bit, reads one after reset and drops on the next edge
`timescale 1ns/100ps
`default_nettype none
module self_clear_bit (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Set request, held as long as the source of reset is held
	input  wire logic set_in,
	// Stored bit
	output var  logic bit_out
);
	import xaui_mdio_pkg::*;

	// Set wins; with no request the bit clears itself on the next edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_out <= CTRL_RESET_INIT;
		end else begin
			bit_out <= set_in;
		end
	end
endmodule : self_clear_bit
`default_nettype wire

// File: rtl/xaui_mdio_base_regs.sv
// Base management registers: control, status and the two identifier words
`timescale 1ns/100ps
`default_nettype none
module xaui_mdio_base_regs
	import xaui_mdio_pkg::*;
#(
	// Identifier bits 3..24, bit 3 at the top; value is arbitrary
	parameter logic [OUI_W-1:0]   OUI_BITS  = 22'h2A5C3E,
	// Model number; value is arbitrary
	parameter logic [MODEL_W-1:0] MODEL_NUM = 6'h15,
	// Revision number; value is arbitrary
	parameter logic [REV_W-1:0]   REV_NUM   = 4'h3
) (
	// Management clock and reset
	input  wire logic            clk_in,
	input  wire logic            rst_n_in,
	// Register access from the frame engine
	input  wire req_type         req_in,
	output var  logic [DATA_W-1:0] reg_rdata_out,
	output var  logic            reg_rvalid_out,
	// Device pins
	input  wire pins_type        pins_in,
	// Controls to the datapath
	output var  logic            global_reset_out,
	output var  logic            loopback_out,
	output var  logic            power_down_out
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// The low identifier word must pack exactly into sixteen bits
	if (ID_LOW_W + MODEL_W + REV_W != DATA_W) begin : g_bad_id_layout
		$error("identifier fields do not fill the low word");
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode

	logic ctrl_wr;
	logic stat_rd;
	logic reset_set;
	logic reset_bit;
	logic link_bit;
	logic powerdown_bit;

	// Only the control word takes writes; all other targets drop them
	assign ctrl_wr = req_in.wr && (req_in.addr == ADDR_CONTROL);
	assign stat_rd = req_in.rd && (req_in.addr == ADDR_STATUS);

	// Reset bit is set by a host write of one or by the reset pin held low
	assign reset_set = (ctrl_wr && req_in.wdata[CTRL_RESET]) || !pins_in.reset_pin_n;

	////////////////////////////////////////////////////////////////////////////
	// Identifier words

	// Builds either identifier word from the parameters
	function automatic logic [DATA_W-1:0] id_word(input logic low_word);
		logic [DATA_W-1:0] w;
		w = ZERO_WORD;
		if (low_word) begin
			w = {OUI_BITS[ID_LOW_W-1:0], MODEL_NUM, REV_NUM};
		end else begin
			w = OUI_BITS[OUI_W-1:ID_LOW_W];
		end
		return w;
	endfunction : id_word

	////////////////////////////////////////////////////////////////////////////
	// Control bits

	// Self-clearing global reset bit
	self_clear_bit u_reset_bit (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.set_in   (reset_set),
		.bit_out  (reset_bit)
	);

	// Loopback: a global reset returns it to its default
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			loopback_out <= LOOPBACK_INIT;
		end else if (reset_bit) begin
			loopback_out <= LOOPBACK_INIT;
		end else if (ctrl_wr) begin
			loopback_out <= req_in.wdata[CTRL_LOOPBACK];
		end
	end

	// Power-down select from software
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			powerdown_bit <= POWERDOWN_INIT;
		end else if (reset_bit) begin
			powerdown_bit <= POWERDOWN_INIT;
		end else if (ctrl_wr) begin
			powerdown_bit <= req_in.wdata[CTRL_POWERDOWN];
		end
	end

	// Effective power-down, registered so the pin term costs one cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_down_out <= POWERDOWN_INIT;
		end else begin
			power_down_out <= powerdown_bit || !pins_in.chip_enable;
		end
	end

	// Effective global reset; also the FIFO clear for the lanes
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			global_reset_out <= CTRL_RESET_INIT;
		end else begin
			global_reset_out <= reset_bit || !pins_in.reset_pin_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link status

	// Latched-low link flag, rearmed by each status read
	latch_low_bit u_link_bit (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.level_in (pins_in.link_up),
		.read_in  (stat_rd),
		.bit_out  (link_bit)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read path

	logic [DATA_W-1:0] next_rdata;

	// Fixed bits are built here; bits 5:0 of control and 7 of status read zero
	always_comb begin
		next_rdata = ZERO_WORD;
		case (req_in.addr)
			ADDR_CONTROL: begin
				next_rdata[CTRL_RESET]     = reset_bit;
				next_rdata[CTRL_LOOPBACK]  = loopback_out;
				next_rdata[CTRL_SPEED_LSB] = 1'b1;
				next_rdata[CTRL_POWERDOWN] = powerdown_bit;
				next_rdata[CTRL_DUPLEX]    = 1'b1;
				next_rdata[CTRL_SPEED_MSB] = 1'b1;
			end
			ADDR_STATUS: begin
				next_rdata[STAT_EXT_STATUS] = 1'b1;
				next_rdata[STAT_LINK]       = link_bit;
				next_rdata[STAT_EXT_CAP]    = 1'b1;
			end
			ADDR_ID_HIGH: begin
				next_rdata = id_word(1'b0);
			end
			ADDR_ID_LOW: begin
				next_rdata = id_word(1'b1);
			end
			default: begin
				next_rdata = ZERO_WORD;
			end
		endcase
	end

	// Read data is captured on the request edge and held until the next read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= ZERO_WORD;
		end else if (req_in.rd) begin
			reg_rdata_out <= next_rdata;
		end
	end

	// One-cycle marker of fresh read data
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= req_in.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	// A reset write raises the bit, then the global reset output one cycle later
	a_reset_write_acts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctrl_wr && req_in.wdata[CTRL_RESET] |=> reset_bit ##1 global_reset_out)
		else $error("reset write did not reach the global reset output");

	// The pin reset alone drives the global reset output
	a_pin_reset_acts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!pins_in.reset_pin_n |=> global_reset_out && reset_bit)
		else $error("reset pin did not assert global reset");

	// Without a new request the reset bit is gone on the next edge after it was set
	a_reset_self_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		reset_bit ##1 !$past(reset_set) |-> !reset_bit ##1 !reset_bit || $past(reset_set))
		else $error("reset bit failed to clear itself");

	// Loopback follows bit 14 of a control write unless a reset is active
	a_loopback_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctrl_wr && !reset_bit |=> loopback_out == $past(req_in.wdata[CTRL_LOOPBACK]))
		else $error("loopback did not follow the control write");

	// Chip enable low forces power-down; register bit low with chip enable high releases it
	a_power_down_or: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		1'b1 |=> power_down_out == ($past(powerdown_bit) || !$past(pins_in.chip_enable)))
		else $error("power-down is not the OR of register and pin");

	// Speed bits read one on every control read
	a_speed_bits_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.rd && req_in.addr == ADDR_CONTROL |=>
		reg_rvalid_out && reg_rdata_out[CTRL_SPEED_LSB] && reg_rdata_out[CTRL_SPEED_MSB])
		else $error("speed selection bits did not read one");

	// Unsupported control features read zero: bits 12, 10, 9 and 7
	a_ctrl_ro_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.rd && req_in.addr == ADDR_CONTROL |=>
		!reg_rdata_out[CTRL_AUTONEG] && !reg_rdata_out[CTRL_ISOLATE] &&
		!reg_rdata_out[CTRL_RESTART] && !reg_rdata_out[CTRL_COLTEST])
		else $error("read-only zero control bit read one");

	// Duplex bit reads one even right after a write of zero
	a_duplex_fixed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctrl_wr ##1 req_in.rd && req_in.addr == ADDR_CONTROL |=> reg_rdata_out[CTRL_DUPLEX])
		else $error("duplex bit did not read one");

	// Status fixed fields
	a_status_fixed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.rd && req_in.addr == ADDR_STATUS |=>
		reg_rdata_out[STAT_EXT_STATUS] && reg_rdata_out[STAT_EXT_CAP] &&
		!reg_rdata_out[STAT_JABBER] && reg_rdata_out[15:9] == 7'h00 &&
		reg_rdata_out[6:3] == 4'h0)
		else $error("status fixed bits read wrong");

	// A down sample shows as zero at the next status read
	a_link_latch_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!pins_in.link_up ##1 stat_rd |=> reg_rvalid_out && !reg_rdata_out[STAT_LINK])
		else $error("latched link down was lost before the read");

	// After a read with the link up, the flag shows up
	a_link_rearm: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		stat_rd && pins_in.link_up |=> link_bit)
		else $error("link flag did not rearm after status read");

	// Identifier words carry the parameter fields in order
	a_id_words: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.rd && (req_in.addr == ADDR_ID_HIGH || req_in.addr == ADDR_ID_LOW) |=>
		reg_rdata_out == ($past(req_in.addr) == ADDR_ID_LOW ?
		{OUI_BITS[ID_LOW_W-1:0], MODEL_NUM, REV_NUM} : OUI_BITS[OUI_W-1:ID_LOW_W]))
		else $error("identifier word mismatch");

	// Unmapped addresses read zero
	a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.rd && req_in.addr > ADDR_ID_LOW |=> reg_rdata_out == ZERO_WORD)
		else $error("unmapped address returned nonzero data");

endmodule : xaui_mdio_base_regs
`default_nettype wire

// File: rtl/xaui_mdio_pkg.sv
// Constants, field layout and carrier types of the base management registers
// Notes on behaviour
// - Control bit 15 is global reset, also FIFO clear; ORed with inverted reset pin.
// - After any reset the reset bit reads 1, then clears itself next cycle.
// - Control bit 14 set puts all lanes in loopback; cleared (default) disables it.
// - Control bit 11 selects power-down, default 0; ORed with inverted chip enable.
// - Speed selection bits 13 and 6 are read-only and read 1.
// - Control bits 12, 10, 9 and 7 are read-only and read 0.
// - Control bit 8 reads 1 for full duplex; writes to it are discarded.
// - Status bit 8 reads 1: extended status lives in register 15 (not mapped here; it reads zero).
// - Status bits 15:9 and 6:3 are read-only zero.
// - Status bit 2 is link up; a down condition holds 0 until status is read.
// - Status bit 0 reads 1 (extended capability); jabber bit 1 reads 0.
// - Identifier registers hold identifier bits 3..24, 6-bit model, revision number.
// - First identifier register shows identifier bits 3..18, most significant first.
// - Second identifier register: identifier bits 19..24, then model, then revision.
// - Writes to read-only bits or registers are ignored; unmapped reads return zero.
package xaui_mdio_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_ID_HIGH = 5'h02;
	localparam logic [ADDR_W-1:0] ADDR_ID_LOW  = 5'h03;

	// Control field positions
	localparam int CTRL_RESET     = 15;
	localparam int CTRL_LOOPBACK  = 14;
	localparam int CTRL_SPEED_LSB = 13;
	localparam int CTRL_AUTONEG   = 12;
	localparam int CTRL_POWERDOWN = 11;
	localparam int CTRL_ISOLATE   = 10;
	localparam int CTRL_RESTART   = 9;
	localparam int CTRL_DUPLEX    = 8;
	localparam int CTRL_COLTEST   = 7;
	localparam int CTRL_SPEED_MSB = 6;

	// Status field positions
	localparam int STAT_EXT_STATUS = 8;
	localparam int STAT_LINK       = 2;
	localparam int STAT_JABBER     = 1;
	localparam int STAT_EXT_CAP    = 0;

	// Identifier layout: high word, then id bits, model and revision in the low word
	localparam int OUI_W      = 22;
	localparam int MODEL_W    = 6;
	localparam int REV_W      = 4;
	localparam int ID_LOW_W   = OUI_W - DATA_W;

	// Reset values
	localparam logic       CTRL_RESET_INIT = 1'b1;
	localparam logic       LOOPBACK_INIT   = 1'b0;
	localparam logic       POWERDOWN_INIT  = 1'b0;
	localparam logic       LINK_INIT       = 1'b0;
	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

	// One management access, as presented by the frame engine
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_type;

	// Device pins that steer the control logic
	typedef struct packed {
		logic reset_pin_n;
		logic chip_enable;
		logic link_up;
	} pins_type;

endpackage : xaui_mdio_pkg

// File: tb/mdio_host_model.sv
// Station manager model that issues register accesses on the strobe port
`timescale 1ns/100ps
`default_nettype none
module mdio_host_model
	import xaui_mdio_pkg::*;
(
	// Clock
	input  wire logic              clk_in,
	// Access port towards the register bank
	output var  req_type           req_out,
	input  wire logic [DATA_W-1:0] rdata_in,
	input  wire logic              rvalid_in
);
	////////////////////////////////////////////////////////////////////////////////
	// Idle strobes from time zero
	initial begin
		req_out = '0;
	end

	// One write; reserved control bits always leave as zero
	task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(posedge clk_in);
		#1;
		req_out = '{rd: 1'b0, wr: 1'b1, addr: addr,
			wdata: (addr == ADDR_CONTROL) ? (data & 16'hFFC0) : data};
		@(posedge clk_in);
		#1;
		req_out = '0;
	endtask : write_reg

	// One read; answer is taken just after the request edge
	task automatic read_reg(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data,
		output logic valid);
		@(posedge clk_in);
		#1;
		req_out = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 16'hFFFF};
		@(posedge clk_in);
		#1;
		req_out = '0;
		valid = rvalid_in;
		// Reserved control bits are disregarded on read
		data = (addr == ADDR_CONTROL) ? (rdata_in & 16'hFFC0) : rdata_in;
	endtask : read_reg
endmodule : mdio_host_model
`default_nettype wire

// File: tb/test_xaui_mdio_base_regs.sv
// Self-checking bench of the base management registers
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp, msg) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("wrong value at %0t: %s", $time, msg); \
	end \
end
module test_xaui_mdio_base_regs
	import xaui_mdio_pkg::*;
;
	// Identifier values, arbitrary
	localparam logic [OUI_W-1:0]   OUI   = 22'h1B2D07;
	localparam logic [MODEL_W-1:0] MODEL = 6'h2A;
	localparam logic [REV_W-1:0]   REV   = 4'h9;
	localparam logic [15:0] CTRL_IDLE = 16'h2140;
	localparam logic [15:0] STAT_UP   = 16'h0105;
	localparam logic [15:0] STAT_DOWN = 16'h0101;
	logic              clk_in = 1'b0;
	logic              rst_n_in = 1'b0;
	req_type           req;
	pins_type          pins = '{reset_pin_n: 1'b1, chip_enable: 1'b1, link_up: 1'b1};
	logic [DATA_W-1:0] rdata;
	logic              rvalid;
	logic              grst;
	logic              lpbk;
	logic              pdn;
	int                bad_count = 0;
	int                tests_run = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Clock, device and host
	always #4 clk_in = ~clk_in;
	xaui_mdio_base_regs #(.OUI_BITS(OUI), .MODEL_NUM(MODEL), .REV_NUM(REV)) u_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .pins_in(pins), .global_reset_out(grst),
		.loopback_out(lpbk), .power_down_out(pdn));
	mdio_host_model u_host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata),
		.rvalid_in(rvalid));
	////////////////////////////////////////////////////////////////////////////////
	// Read through the host and compare
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e, input string m);
		logic [15:0] d;
		logic        v;
		u_host.read_reg(a, d, v);
		`CHECK(v, 1'b1, "no read answer")
		`CHECK(d, e, m)
	endtask : rd_chk

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cycles

	// Read at the first edge after release sees the reset bit set
	task automatic t_reset();
		fork
			rd_chk(ADDR_CONTROL, 16'hA140, "ctrl after reset");
			begin
				@(posedge clk_in);
				#1;
				rst_n_in = 1'b1;
			end
		join
		`CHECK(grst, 1'b1, "reset still active")
		`CHECK(lpbk, 1'b0, "loopback default")
		`CHECK(pdn, 1'b0, "power down default")
		cycles(1);
		`CHECK(grst, 1'b0, "reset released")
		rd_chk(ADDR_CONTROL, CTRL_IDLE, "ctrl self cleared");
	endtask : t_reset

	// Link flag latches low until status is read
	task automatic t_link();
		rd_chk(ADDR_STATUS, STAT_DOWN, "link reset low");
		rd_chk(ADDR_STATUS, STAT_UP, "status up");
		pins.link_up = 1'b0;
		cycles(1);
		pins.link_up = 1'b1;
		cycles(2);
		rd_chk(ADDR_STATUS, STAT_DOWN, "link drop latched");
		rd_chk(ADDR_STATUS, STAT_UP, "link follows again");
	endtask : t_link

	// Writable and fixed control bits
	task automatic t_ctrl();
		u_host.write_reg(ADDR_CONTROL, 16'h7FC0);
		rd_chk(ADDR_CONTROL, 16'h6940, "ctrl bits set");
		`CHECK(lpbk, 1'b1, "loopback on")
		`CHECK(pdn, 1'b1, "power down on")
		u_host.write_reg(ADDR_CONTROL, 16'h0000);
		rd_chk(ADDR_CONTROL, CTRL_IDLE, "duplex and speed fixed");
		`CHECK(lpbk, 1'b0, "loopback off")
		`CHECK(pdn, 1'b0, "power down off")
	endtask : t_ctrl

	// Reset and chip-enable pins act through the outputs
	task automatic t_pins();
		pins.reset_pin_n = 1'b0;
		cycles(2);
		`CHECK(grst, 1'b1, "pin reset")
		rd_chk(ADDR_CONTROL, 16'hA140, "reset bit held by pin");
		pins.reset_pin_n = 1'b1;
		cycles(3);
		`CHECK(grst, 1'b0, "pin reset gone")
		pins.chip_enable = 1'b0;
		cycles(2);
		`CHECK(pdn, 1'b1, "pin power down")
		rd_chk(ADDR_CONTROL, CTRL_IDLE, "register bit not pin");
		pins.chip_enable = 1'b1;
		cycles(2);
		`CHECK(pdn, 1'b0, "pin power down gone")
	endtask : t_pins

	// Software reset clears loopback and power down, then clears itself
	task automatic t_soft_reset();
		u_host.write_reg(ADDR_CONTROL, 16'h4800);
		cycles(1);
		`CHECK(lpbk, 1'b1, "loopback before reset")
		u_host.write_reg(ADDR_CONTROL, 16'h8000);
		cycles(1);
		`CHECK(grst, 1'b1, "soft reset active")
		`CHECK(lpbk, 1'b0, "loopback cleared")
		cycles(1);
		`CHECK(grst, 1'b0, "soft reset over")
		`CHECK(pdn, 1'b0, "power down cleared")
		rd_chk(ADDR_CONTROL, CTRL_IDLE, "reset bit cleared");
	endtask : t_soft_reset

	// Identifier words, read-only and unmapped places
	task automatic t_ident();
		rd_chk(ADDR_ID_HIGH, OUI[21:6], "id high word");
		rd_chk(ADDR_ID_LOW, {OUI[5:0], MODEL, REV}, "id low word");
		u_host.write_reg(ADDR_ID_HIGH, 16'hFFFF);
		u_host.write_reg(ADDR_STATUS, 16'hFFFF);
		u_host.write_reg(5'h04, 16'hFFFF);
		rd_chk(ADDR_ID_HIGH, OUI[21:6], "id write ignored");
		rd_chk(ADDR_STATUS, STAT_UP, "status write ignored");
		rd_chk(5'h04, ZERO_WORD, "unmapped read");
		rd_chk(5'h0F, ZERO_WORD, "unmapped read");
		rd_chk(5'h1F, ZERO_WORD, "unmapped read");
		rd_chk(ADDR_CONTROL, CTRL_IDLE, "ctrl untouched");
	endtask : t_ident

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; reset spans four edges
	initial begin
		repeat (3) @(posedge clk_in);
		t_reset();
		t_link();
		t_ctrl();
		t_pins();
		t_soft_reset();
		t_ident();
		complete_run();
	end

	// Watchdog, far beyond the 71 cycles needed
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
endmodule : test_xaui_mdio_base_regs
`default_nettype wire
